// file: pkg/size_detect_pkg.sv
// package: constants and carrier types for the original size detector
package size_detect_pkg;

	// sensor pattern order: length far, length near, width far, width near
	localparam int SENSOR_W = 4;
	localparam int DISPLAY_W = 8;
	localparam int LENGTH_W = 16;

	// decoded size codes
	typedef enum logic [3:0] {
		SIZE_NONE = 4'h0,
		SIZE_A3 = 4'h1,
		SIZE_B4 = 4'h2,
		SIZE_FOLIO = 4'h3,
		SIZE_A4_SEF = 4'h4,
		SIZE_A4_LEF = 4'h5,
		SIZE_B5_LEF = 4'h6,
		SIZE_A5_LEF = 4'h7,
		SIZE_FOLIO_INCH = 4'h8,
		SIZE_UNKNOWN = 4'hF
	} size_code_t;

	// sensor patterns of the decode table
	localparam logic [3:0] PAT_A3 = 4'hF;
	localparam logic [3:0] PAT_B4 = 4'hD;
	localparam logic [3:0] PAT_FOLIO = 4'hC;
	localparam logic [3:0] PAT_A4_SEF = 4'h4;
	localparam logic [3:0] PAT_A4_LEF = 4'h3;
	localparam logic [3:0] PAT_B5_LEF = 4'h1;
	localparam logic [3:0] PAT_A5_LEF = 4'h0;
	localparam logic [3:0] PAT_FOLIO_INCH = 4'h5;
	localparam logic [3:0] DISPLAY_PAD = 4'h0;

	// raw active-low sensor levels
	typedef struct packed {
		logic length_sensor_far;
		logic length_sensor_near;
		logic width_sensor_far;
		logic width_sensor_near;
	} auto_size_sensors_t;

	// decision handed to the engine controller
	typedef struct packed {
		size_code_t size;
		logic [DISPLAY_W-1:0] display;
		logic undetectable;
		logic short_edge_first;
		logic full_area;
	} size_result_t;

	localparam logic [1:0] SYNC_RESET = 2'h0;
	localparam logic [2:0] SYNC3_RESET = 3'h7;

endpackage : size_detect_pkg

// file: hw/original_size_detector.sv
// original size detector: sensor sampling, size decode, by-pass laser gate
//
// Operation
// - sensor levels are synchronised and tracked every cycle while powered
// - size is decoded on the platen cover sensor turning active
// - with platen open, size is decoded on the start key press
// - sensor low means paper present, decoded as one
// - eight listed patterns decode to sizes; display shows bits plus four zeros
// - unlisted patterns flag undetectable size unless setting is non-default
// - by-pass feed ignores sensors for the size (display still shows them), assumes short edge first, scans full area
// - by-pass laser video stops once registered paper length is reached
`timescale 1ns/1ns

module original_size_detector #(
	parameter int LENGTH_W = size_detect_pkg::LENGTH_W
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire size_detect_pkg::auto_size_sensors_t auto_size_sensors_i,
	input wire logic platen_cover_sensor_i,
	input wire logic platen_open_i,
	input wire logic start_key_i,
	input wire logic undetectable_size_setting_i,
	input wire logic bypass_feed_i,
	input wire logic page_start_i,
	input wire logic line_pulse_i,
	input wire logic [LENGTH_W-1:0] registered_length_i,
	input wire logic laser_video_i,
	output size_detect_pkg::size_result_t result_o,
	output logic [size_detect_pkg::SENSOR_W-1:0] sensor_bits_o,
	output logic result_valid_o,
	output logic laser_video_o,
	output logic laser_cut_o
);

	// --------------------------------------------------------------
	// input synchronisers
	// --------------------------------------------------------------
	logic [2:0] sync_sensor [size_detect_pkg::SENSOR_W];
	logic [2:0] sync_cover;
	logic [2:0] sync_start;
	logic [size_detect_pkg::SENSOR_W-1:0] sensor_level;
	logic cover_level;
	logic start_level;
	logic cover_prev;
	logic start_prev;
	logic [size_detect_pkg::SENSOR_W-1:0] raw_sensors;

	assign raw_sensors = auto_size_sensors_i;

	// three stage chains; a new level is taken once stages two and three agree
	// stage one may be metastable, so only stages two and three are ever read
	// sensor chains reset to the idle high level so no paper is seen out of reset
	always_ff @(posedge clock_i) begin
		for (int i = 0; i < size_detect_pkg::SENSOR_W; i++) begin
			if (!rst_n_i) begin
				sync_sensor[i] <= size_detect_pkg::SYNC3_RESET;
			end else begin
				sync_sensor[i] <= {sync_sensor[i][1:0], raw_sensors[i]};
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sync_cover <= '0;
			sync_start <= '0;
		end else begin
			sync_cover <= {sync_cover[1:0], platen_cover_sensor_i};
			sync_start <= {sync_start[1:0], start_key_i};
		end
	end

	// filtered levels, sensors held high (no paper) out of reset
	// a glitch shorter than two cycles never reaches these levels
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sensor_level <= '1;
			cover_level <= 1'h0;
			start_level <= 1'h0;
		end else begin
			for (int i = 0; i < size_detect_pkg::SENSOR_W; i++) begin
				if (sync_sensor[i][1] == sync_sensor[i][2]) begin
					sensor_level[i] <= sync_sensor[i][2];
				end
			end
			if (sync_cover[1] == sync_cover[2]) begin
				cover_level <= sync_cover[2];
			end
			if (sync_start[1] == sync_start[2]) begin
				start_level <= sync_start[2];
			end
		end
	end

	// edge history for the sampling events
	// both reset to the idle low level, so no false edge follows reset
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			cover_prev <= 1'h0;
			start_prev <= 1'h0;
		end else begin
			cover_prev <= cover_level;
			start_prev <= start_level;
		end
	end

	// --------------------------------------------------------------
	// decode
	// --------------------------------------------------------------
	logic [size_detect_pkg::SENSOR_W-1:0] pattern;
	logic cover_event;
	logic start_event;
	logic sample;

	// sensor low means paper, so the pattern is the inverted filtered level
	assign pattern = ~sensor_level;
	assign cover_event = cover_level && !cover_prev;
	assign start_event = start_level && !start_prev && platen_open_i;
	assign sample = cover_event || start_event;

	// maps a sensor pattern to a size code
	function automatic size_detect_pkg::size_code_t decode_size(input logic [3:0] pat);
		if (pat == size_detect_pkg::PAT_A3) begin
			return size_detect_pkg::SIZE_A3;
		end else if (pat == size_detect_pkg::PAT_B4) begin
			return size_detect_pkg::SIZE_B4;
		end else if (pat == size_detect_pkg::PAT_FOLIO) begin
			return size_detect_pkg::SIZE_FOLIO;
		end else if (pat == size_detect_pkg::PAT_A4_SEF) begin
			return size_detect_pkg::SIZE_A4_SEF;
		end else if (pat == size_detect_pkg::PAT_A4_LEF) begin
			return size_detect_pkg::SIZE_A4_LEF;
		end else if (pat == size_detect_pkg::PAT_B5_LEF) begin
			return size_detect_pkg::SIZE_B5_LEF;
		end else if (pat == size_detect_pkg::PAT_A5_LEF) begin
			return size_detect_pkg::SIZE_A5_LEF;
		end else if (pat == size_detect_pkg::PAT_FOLIO_INCH) begin
			return size_detect_pkg::SIZE_FOLIO_INCH;
		end else begin
			return size_detect_pkg::SIZE_UNKNOWN;
		end
	endfunction : decode_size

	size_detect_pkg::size_code_t next_size;

	assign next_size = decode_size(pattern);

	// live pattern for monitoring, tracked regardless of sampling
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sensor_bits_o <= '0;
		end else begin
			sensor_bits_o <= pattern;
		end
	end

	// first sampling event marks the result as usable
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			result_valid_o <= 1'h0;
		end else if (sample) begin
			result_valid_o <= 1'h1;
		end
	end

	// latch result at each sampling event and hold it otherwise
	// by-pass feeding overrides the sensors: the largest area is scanned short edge first
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			result_o <= '0;
		end else if (sample) begin
			result_o.display <= {pattern, size_detect_pkg::DISPLAY_PAD};
			if (bypass_feed_i) begin
				result_o.size <= size_detect_pkg::SIZE_A3;
				result_o.undetectable <= 1'h0;
				result_o.short_edge_first <= 1'h1;
				result_o.full_area <= 1'h1;
			end else begin
				result_o.size <= next_size;
				result_o.undetectable <= (next_size == size_detect_pkg::SIZE_UNKNOWN)
					&& !undetectable_size_setting_i;
				result_o.short_edge_first <= 1'h0;
				result_o.full_area <= 1'h0;
			end
		end
	end

	// --------------------------------------------------------------
	// by-pass laser gate
	// --------------------------------------------------------------
	logic [LENGTH_W-1:0] line_count;
	logic [LENGTH_W-1:0] length_limit;

	// capture the registered length and count lines for each page
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			line_count <= '0;
			length_limit <= '0;
		end else if (page_start_i) begin
			line_count <= '0;
			length_limit <= registered_length_i;
		end else if (line_pulse_i && line_count != length_limit) begin
			line_count <= line_count + 1'h1;
		end
	end

	// the page length is reached once the line count meets the captured limit
	// a new page start releases the cut in the same cycle, so no line is lost
	logic length_reached;

	assign length_reached = bypass_feed_i && !page_start_i && line_count == length_limit;

	// cut video once the page length is reached in by-pass operation
	// outside by-pass feeding the video passes with one cycle of delay
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			laser_cut_o <= 1'h0;
			laser_video_o <= 1'h0;
		end else begin
			laser_cut_o <= length_reached;
			laser_video_o <= laser_video_i && !length_reached;
		end
	end

endmodule : original_size_detector

// file: test/size_detect_props.sv
// checker: port assertions of the original size detector
`timescale 1ns/1ns
module size_detect_props (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire size_detect_pkg::auto_size_sensors_t auto_size_sensors_i,
	input wire logic platen_cover_sensor_i,
	input wire logic platen_open_i,
	input wire logic start_key_i,
	input wire logic undetectable_size_setting_i,
	input wire logic bypass_feed_i,
	input wire logic laser_video_i,
	input wire size_detect_pkg::size_result_t result_o,
	input wire logic [size_detect_pkg::SENSOR_W-1:0] sensor_bits_o,
	input wire logic laser_video_o,
	input wire logic laser_cut_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	a_bits_track: assert property ($stable(auto_size_sensors_i)[*6] |-> sensor_bits_o == ~auto_size_sensors_i)
		else $error("sensor bits do not follow the pins");
	a_cover_decode: assert property (($stable(auto_size_sensors_i)[*6] ##1
		($rose(platen_cover_sensor_i) && !bypass_feed_i))
		|-> ##6 result_o.display == {~$past(auto_size_sensors_i, 6), 4'h0})
		else $error("cover sample decoded wrong");
	a_start_decode: assert property (($stable(auto_size_sensors_i)[*6] ##1
		($rose(start_key_i) && platen_open_i && !bypass_feed_i))
		|-> ##6 result_o.display == {~$past(auto_size_sensors_i, 6), 4'h0})
		else $error("start sample decoded wrong");
	a_start_refused: assert property ($rose(start_key_i) && !platen_open_i && !platen_cover_sensor_i
		|-> ##1 $stable(result_o)[*8])
		else $error("closed platen start changed result");
	a_result_hold: assert property ($changed(result_o) |-> $past(platen_cover_sensor_i, 3) || $past(start_key_i, 3))
		else $error("result changed without an event");
	a_undetect_flag: assert property ($changed(result_o) && result_o.size == size_detect_pkg::SIZE_UNKNOWN
		|-> result_o.undetectable == !undetectable_size_setting_i)
		else $error("undetectable flag wrong");
	a_bypass_full: assert property ($changed(result_o) && bypass_feed_i
		|-> result_o.size == size_detect_pkg::SIZE_A3 && result_o.short_edge_first && result_o.full_area)
		else $error("bypass result wrong");
	a_laser_gate: assert property (laser_cut_o && $past(laser_cut_o) |-> !laser_video_o)
		else $error("video passes after cut");
	a_video_pass: assert property (!laser_cut_o && !$past(laser_cut_o) |-> laser_video_o == $past(laser_video_i))
		else $error("video not passed through");
endmodule : size_detect_props
bind original_size_detector size_detect_props i_size_detect_props (.clock_i, .rst_n_i, .auto_size_sensors_i,
	.platen_cover_sensor_i, .platen_open_i, .start_key_i, .undetectable_size_setting_i, .bypass_feed_i,
	.laser_video_i, .result_o, .sensor_bits_o, .laser_video_o, .laser_cut_o);

// file: test/size_sensor_model.sv
// partner: reflective size sensors and platen cover sensor
`timescale 1ns/1ns
module size_sensor_model (
	input wire logic clock_i,
	input wire logic [3:0] paper_i,
	input wire logic lower_i,
	output size_detect_pkg::auto_size_sensors_t sensors_o,
	output logic cover_o
);
	// a sensor pulls low where paper lies on the glass
	assign sensors_o = ~paper_i;
	// cover sensor trips as the platen comes down
	initial cover_o = 1'h0;
	always @(posedge clock_i) begin
		cover_o <= lower_i;
	end
endmodule : size_sensor_model

// file: test/tb_top.sv
// testbench: scenarios for the original size detector
`timescale 1ns/1ns
module tb_top;
	logic clock_i = 1'h0, rst_n_i = 1'h0, platen_open_i = 1'h0, start_key_i = 1'h0, lower = 1'h0;
	logic undetectable_size_setting_i = 1'h0, bypass_feed_i = 1'h0, page_start_i = 1'h0, line_pulse_i = 1'h0;
	logic laser_video_i = 1'h0, platen_cover_sensor_i, result_valid_o, laser_video_o, laser_cut_o;
	logic [3:0] paper = 4'h0, sensor_bits_o;
	logic [15:0] registered_length_i = 16'h0003;
	size_detect_pkg::auto_size_sensors_t auto_size_sensors_i;
	size_detect_pkg::size_result_t result_o;
	int errors = 0, num_checks = 0, cycles = 0;
	size_sensor_model i_size_sensor_model (.clock_i, .paper_i(paper), .lower_i(lower),
		.sensors_o(auto_size_sensors_i), .cover_o(platen_cover_sensor_i));
	original_size_detector i_original_size_detector (.clock_i, .rst_n_i, .auto_size_sensors_i,
		.platen_cover_sensor_i, .platen_open_i, .start_key_i, .undetectable_size_setting_i, .bypass_feed_i,
		.page_start_i, .line_pulse_i, .registered_length_i, .laser_video_i, .result_o, .sensor_bits_o,
		.result_valid_o, .laser_video_o, .laser_cut_o);
	initial forever #10 clock_i = ~clock_i;
	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : step
	// every listed pattern plus one unlisted, sampled by the cover
	task automatic t_cover;
		logic [3:0] pats [9] = '{4'hF, 4'hD, 4'hC, 4'h4, 4'h3, 4'h1, 4'h0, 4'h5, 4'hA};
		logic [3:0] sizes [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hF};
		for (int i = 0; i < 9; i++) begin
			paper = pats[i];
			step(8);
			check(sensor_bits_o, pats[i]);
			lower = 1'h1;
			step(8);
			check(result_o.size, sizes[i]);
			check(result_o.display, {pats[i], 4'h0});
			check(result_o.undetectable, i == 8);
			check(result_valid_o, 1'h1);
			check({result_o.short_edge_first, result_o.full_area}, 2'h0);
			lower = 1'h0;
			step(2);
		end
		$display("test cover done");
	endtask : t_cover
	// start key refused while closed, taken while open, flag suppressed
	task automatic t_start;
		paper = 4'hF;
		step(8);
		start_key_i = 1'h1;
		step(8);
		check(result_o.size, 4'hF);
		start_key_i = 1'h0;
		paper = 4'h3;
		platen_open_i = 1'h1;
		step(8);
		start_key_i = 1'h1;
		step(8);
		check(result_o.size, 4'h5);
		start_key_i = 1'h0;
		undetectable_size_setting_i = 1'h1;
		paper = 4'hA;
		step(8);
		start_key_i = 1'h1;
		step(8);
		check(result_o.undetectable, 1'h0);
		start_key_i = 1'h0;
		platen_open_i = 1'h0;
		$display("test start done");
	endtask : t_start
	// by-pass feed ignores the small original on the glass
	task automatic t_bypass;
		paper = 4'h0;
		bypass_feed_i = 1'h1;
		lower = 1'h1;
		step(8);
		check({result_o.size, result_o.short_edge_first, result_o.full_area}, 6'h07);
		lower = 1'h0;
		$display("test bypass done");
	endtask : t_bypass
	// video cut once three lines of the registered length pass
	task automatic t_laser;
		laser_video_i = 1'h1;
		page_start_i = 1'h1;
		step(1);
		page_start_i = 1'h0;
		step(2);
		check(laser_video_o, 1'h1);
		line_pulse_i = 1'h1;
		step(3);
		line_pulse_i = 1'h0;
		step(2);
		check({laser_cut_o, laser_video_o}, 2'h2);
		bypass_feed_i = 1'h0;
		step(1);
		check({laser_cut_o, laser_video_o}, 2'h1);
		$display("test laser done");
	endtask : t_laser
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	// cut a hang short
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			end_of_test;
		end
	end
	initial begin
		step(4);
		rst_n_i = 1'h1;
		step(2);
		t_cover;
		t_start;
		t_bypass;
		t_laser;
		end_of_test;
	end
endmodule : tb_top
